// >>> smd_pkg.sv
// package for the shift/move datapath slice
// assumes an 8-bit core with 7-bit file addresses
package smd_pkg;
  // ==========================================================
  // widths and positions
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned MSB_POS = 7;
  localparam int unsigned LSB_POS = 0;
  localparam int unsigned FILE_DEPTH = 128;
  // ==========================================================
  // reset values
  localparam logic [7:0] W_RST    = 8'h00;
  localparam logic       FLAG_RST = 1'b0;
  localparam logic       DEST_W   = 1'b0;
  localparam logic       DEST_F   = 1'b1;
  // ==========================================================
  // operation codes
  typedef enum logic [1:0]
  {
    SMD_NOP                   = 2'b00,
    SMD_LOGICAL_SHIFT_LEFT_OP = 2'b01,
    SMD_LOGICAL_SHIFT_RIGHT_OP = 2'b10,
    SMD_MOVE_FILE_OP          = 2'b11
  } smd_op_t;
endpackage

// >>> smd_file_mem.sv
// file register memory, 128 x 8, registered read data
// assumes write and read addresses come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module smd_file_mem
(
  input  wire logic       clk,
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data
);
  logic [7:0] mem [0:smd_pkg::FILE_DEPTH-1];
  // no reset: contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // smd_file_mem
`default_nettype wire

// >>> smd_datapath.sv
// shift/move datapath: left shift, right shift, move of a file register
// assumes OP/ADDR/DEST stand at one taking edge per operation, NOP otherwise
// Behaviour
// RULE_01 - left shift: msb to carry, bits up
// RULE_02 - left shift fills lsb with zero
// RULE_03 - right shift: lsb to carry, bits down
// RULE_04 - right shift fills msb with zero
// RULE_05 - shift result to W or file by dest
// RULE_06 - move copies file value unchanged
// RULE_07 - move dest one file, zero W
// RULE_08 - move updates zero flag from value
// RULE_09 - shift sets zero flag from result
// RULE_10 - flags and write commit same cycle
`timescale 1ns/10ps
`default_nettype none
module smd_datapath
(
  input  wire logic                 CLK,
  input  wire logic                 SYS_RST,
  input  wire smd_pkg::smd_op_t     OP,
  input  wire logic [6:0]           ADDR,
  input  wire logic                 DEST,
  input  wire logic                 FILE_WR,
  input  wire logic [7:0]           FILE_WDATA,
  output logic      [7:0]           W_REG,
  output logic                      CARRY,
  output logic                      ZERO,
  output logic                      DONE
);
  // ==========================================================
  // operand fetch
  logic [7:0]        operand;
  logic              fetch_r;
  logic              fetch_nxt;
  smd_pkg::smd_op_t  op_r;
  smd_pkg::smd_op_t  op_nxt;
  logic [6:0]        addr_r;
  logic [6:0]        addr_nxt;
  logic              dest_r;
  logic              dest_nxt;
  logic [7:0]        result;
  logic              res_carry;
  logic              res_zero;
  logic              wr_file;
  logic              mem_wr;
  logic [7:0]        mem_wdata;
  logic [6:0]        mem_waddr;
  // external writes yield to an executing write-back
  assign mem_wr    = wr_file | FILE_WR;
  assign mem_wdata = wr_file ? result : FILE_WDATA;
  assign mem_waddr = wr_file ? addr_r : ADDR;
  // read before write: an op right after a write-back sees the old value
  smd_file_mem u_mem
  (
    .clk     (CLK),
    .rd_addr (ADDR),
    .rd_data (operand),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata)
  );
  always_comb
  begin
    fetch_nxt = (OP != smd_pkg::SMD_NOP);
    op_nxt    = OP;
    addr_nxt  = ADDR;
    dest_nxt  = DEST;
  end
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      fetch_r <= 1'b0;
      op_r    <= smd_pkg::SMD_NOP;
      addr_r  <= '0;
      dest_r  <= smd_pkg::DEST_W;
    end
    else
    begin
      fetch_r <= fetch_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      dest_r  <= dest_nxt;
    end
  end
  // ==========================================================
  // decode helpers
  // shifts alone touch carry; move and nop leave it standing
  function automatic logic is_shift(input smd_pkg::smd_op_t o);
    is_shift = (o == smd_pkg::SMD_LOGICAL_SHIFT_LEFT_OP) ||
               (o == smd_pkg::SMD_LOGICAL_SHIFT_RIGHT_OP);
  endfunction
  // ==========================================================
  // execute
  always_comb
  begin
    result    = operand;
    res_carry = CARRY;
    unique case (op_r)
      smd_pkg::SMD_LOGICAL_SHIFT_LEFT_OP:
      begin
        res_carry = operand[smd_pkg::MSB_POS];   // see RULE_01
        result    = {operand[6:0], 1'b0};        // see RULE_01 see RULE_02
      end
      smd_pkg::SMD_LOGICAL_SHIFT_RIGHT_OP:
      begin
        res_carry = operand[smd_pkg::LSB_POS];   // see RULE_03
        result    = {1'b0, operand[7:1]};        // see RULE_03 see RULE_04
      end
      smd_pkg::SMD_MOVE_FILE_OP:
      begin
        result = operand;                        // see RULE_06
      end
      smd_pkg::SMD_NOP:
      begin
        result = operand;
      end
    endcase
    res_zero = (result == 8'h00);                // see RULE_08 see RULE_09
    wr_file  = fetch_r && (dest_r == smd_pkg::DEST_F); // see RULE_05 see RULE_07
  end
  // ==========================================================
  // commit: W, flags and file write in one edge
  logic [7:0] w_nxt;
  logic       carry_nxt;
  logic       zero_nxt;
  always_comb
  begin
    w_nxt     = W_REG;
    carry_nxt = CARRY;
    zero_nxt  = ZERO;
    if (fetch_r)
    begin
      if (dest_r == smd_pkg::DEST_W)
      begin
        w_nxt = result;                          // see RULE_05 see RULE_07
      end
      zero_nxt = res_zero;                       // see RULE_08 see RULE_09 see RULE_10
      if (is_shift(op_r))
      begin
        carry_nxt = res_carry;                   // see RULE_10
      end
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      W_REG <= smd_pkg::W_RST;
      CARRY <= smd_pkg::FLAG_RST;
      ZERO  <= smd_pkg::FLAG_RST;
      DONE  <= 1'b0;
    end
    else
    begin
      W_REG <= w_nxt;
      CARRY <= carry_nxt;
      ZERO  <= zero_nxt;
      DONE  <= fetch_r;
    end
  end
  // ==========================================================
  // checks
  left_carry_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && op_r == smd_pkg::SMD_LOGICAL_SHIFT_LEFT_OP |=> CARRY == $past(operand[7])) // see RULE_01
    else $error("left shift carry wrong");
  left_fill_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && dest_r == 1'b0 && op_r == smd_pkg::SMD_LOGICAL_SHIFT_LEFT_OP
    |=> W_REG == {$past(operand[6:0]), 1'b0}) // see RULE_02
    else $error("left shift result wrong");
  right_carry_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && op_r == smd_pkg::SMD_LOGICAL_SHIFT_RIGHT_OP |=> CARRY == $past(operand[0])) // see RULE_03
    else $error("right shift carry wrong");
  right_fill_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && dest_r == 1'b0 && op_r == smd_pkg::SMD_LOGICAL_SHIFT_RIGHT_OP
    |=> W_REG == {1'b0, $past(operand[7:1])}) // see RULE_04
    else $error("right shift result wrong");
  sequence wb_issue_s;
    mem_wr && mem_waddr == addr_r && mem_wdata == result;
  endsequence
  sequence w_held_s;
    $stable(W_REG);
  endsequence
  file_dest_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && dest_r == 1'b1 |-> wb_issue_s ##1 w_held_s) // see RULE_05
    else $error("file write-back wrong");
  move_copy_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && !dest_r && op_r == smd_pkg::SMD_MOVE_FILE_OP
    |=> W_REG == $past(operand) && $stable(CARRY)) // see RULE_06
    else $error("move copy wrong");
  move_dest_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && op_r == smd_pkg::SMD_MOVE_FILE_OP && dest_r
    |-> mem_wr && mem_waddr == addr_r && mem_wdata == operand) // see RULE_07
    else $error("move destination wrong");
  zero_flag_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r |=> ZERO == ($past(result) == 8'h00)) // see RULE_08
    else $error("zero flag wrong");
  one_cycle_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r |=> DONE) // see RULE_10
    else $error("operation not single cycle");
  left_zero_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && op_r == smd_pkg::SMD_LOGICAL_SHIFT_LEFT_OP
    |=> ZERO == ($past(operand[6:0]) == 7'h00)) // see RULE_09
    else $error("left shift zero flag wrong");
  right_zero_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && op_r == smd_pkg::SMD_LOGICAL_SHIFT_RIGHT_OP
    |=> ZERO == ($past(operand[7:1]) == 7'h00)) // see RULE_09
    else $error("right shift zero flag wrong");
  left_wb_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && dest_r && op_r == smd_pkg::SMD_LOGICAL_SHIFT_LEFT_OP
    |-> mem_wdata == {operand[6:0], 1'b0}) // see RULE_05
    else $error("left shift write-back wrong");
  right_wb_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && dest_r && op_r == smd_pkg::SMD_LOGICAL_SHIFT_RIGHT_OP
    |-> mem_wdata == {1'b0, operand[7:1]}) // see RULE_05
    else $error("right shift write-back wrong");
  move_carry_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    fetch_r && op_r == smd_pkg::SMD_MOVE_FILE_OP |=> $stable(CARRY)) // see RULE_06
    else $error("move changed carry");
  idle_hold_a : assert property (@(posedge CLK) disable iff (SYS_RST)
    !fetch_r |=> $stable(W_REG) && $stable(CARRY) && $stable(ZERO) && !DONE) // see RULE_10
    else $error("state moved without an operation");
endmodule // smd_datapath
`default_nettype wire

// >>> smd_core_model.sv
// core sequencer and file loader model facing the datapath
// assumes one clock; drives just after rising edges
`timescale 1ns/10ps
`default_nettype none
module smd_core_model
(
  input  wire logic        clk,
  output smd_pkg::smd_op_t op,
  output logic [6:0]       addr,
  output logic             dest,
  output logic             file_wr,
  output logic [7:0]       file_wdata
);
  initial
  begin
    op = smd_pkg::SMD_NOP;
    addr = 7'h00;
    dest = 1'b0;
    file_wr = 1'b0;
    file_wdata = 8'h00;
  end
  // released addr and file_wdata show the inverse and file_wr drops; op and dest are left as they were
  task automatic load(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    file_wdata <= d;
    file_wr <= 1'b1;
    @(posedge clk);
    file_wr <= 1'b0;
    file_wdata <= ~d;
    addr <= ~a;
  endtask
  // one op, held for its taking edge; returns just after commit
  task automatic issue(input smd_pkg::smd_op_t o, input logic [6:0] a, input logic d);
    @(posedge clk);
    op <= o;
    addr <= a;
    dest <= d;
    @(posedge clk);
    op <= smd_pkg::SMD_NOP;
    addr <= ~a;
    dest <= ~d;
    @(posedge clk);
    #1;
  endtask
endmodule // smd_core_model
`default_nettype wire

// >>> shift_move_datapath_test.sv
// self-checking bench for the shift/move datapath
// assumes smd_core_model drives every op and file load
`timescale 1ns/10ps
`default_nettype none
module shift_move_datapath_test;
  localparam smd_pkg::smd_op_t SL = smd_pkg::SMD_LOGICAL_SHIFT_LEFT_OP;
  localparam smd_pkg::smd_op_t SR = smd_pkg::SMD_LOGICAL_SHIFT_RIGHT_OP;
  localparam smd_pkg::smd_op_t MV = smd_pkg::SMD_MOVE_FILE_OP;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  smd_pkg::smd_op_t op;
  logic [6:0] addr;
  logic dest, file_wr, done, carry, zero;
  logic [7:0] file_wdata, w_reg;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  smd_core_model core (.clk(clk), .op(op), .addr(addr), .dest(dest), .file_wr(file_wr),
    .file_wdata(file_wdata));
  smd_datapath dut (.CLK(clk), .SYS_RST(sys_rst), .OP(op), .ADDR(addr), .DEST(dest),
    .FILE_WR(file_wr), .FILE_WDATA(file_wdata), .W_REG(w_reg), .CARRY(carry),
    .ZERO(zero), .DONE(done));
  // ==========================================================
  // helpers
  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok)
    begin
      n_errors++;
      $display("FAIL %0t %s w=%h c=%b z=%b", $time, m, w_reg, carry, zero);
    end
  endtask
  // one-cycle commit and a one-cycle done pulse
  task automatic run(input smd_pkg::smd_op_t o, input logic [6:0] a, input logic d,
                     input logic [7:0] ew, input logic ec, input logic ez);
    core.issue(o, a, d);
    chk(w_reg === ew && carry === ec && zero === ez && done === 1'b1, "result");
    @(posedge clk);
    #1;
    chk(done === 1'b0, "done pulse");
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic test_left;
    core.load(7'h05, 8'h81);
    run(SL, 7'h05, 1'b0, 8'h02, 1'b1, 1'b0);
    core.load(7'h06, 8'h40);
    run(SL, 7'h06, 1'b0, 8'h80, 1'b0, 1'b0);
    core.load(7'h07, 8'h80);
    run(SL, 7'h07, 1'b1, 8'h80, 1'b1, 1'b1);
    run(MV, 7'h07, 1'b0, 8'h00, 1'b1, 1'b1);
  endtask
  task automatic test_right;
    core.load(7'h08, 8'h01);
    run(SR, 7'h08, 1'b0, 8'h00, 1'b1, 1'b1);
    core.load(7'h09, 8'hff);
    run(SR, 7'h09, 1'b1, 8'h00, 1'b1, 1'b0);
    run(MV, 7'h09, 1'b0, 8'h7f, 1'b1, 1'b0);
  endtask
  task automatic test_move;
    core.load(7'h0a, 8'h00);
    run(MV, 7'h0a, 1'b1, 8'h7f, 1'b1, 1'b1);
    core.load(7'h0b, 8'ha5);
    run(MV, 7'h0b, 1'b1, 8'h7f, 1'b1, 1'b0);
    run(MV, 7'h0b, 1'b0, 8'ha5, 1'b1, 1'b0);
    core.issue(smd_pkg::SMD_NOP, 7'h0a, 1'b0);
    chk(w_reg === 8'ha5 && done === 1'b0, "nop acted");
  endtask
  // generous ceiling; the whole run needs about 60 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(w_reg === 8'h00 && carry === 1'b0 && zero === 1'b0 && done === 1'b0, "reset");
    test_left();
    test_right();
    test_move();
    give_verdict();
  end
endmodule // shift_move_datapath_test
`default_nettype wire
